/* File: design/jtp_params.svh */
// constants of the test access port block
`ifndef JTP_PARAMS_SVH
`define JTP_PARAMS_SVH
`define JTP_IR_W        4
`define JTP_IR_CAPTURE  4'h1
`define JTP_OP_EXTEST   4'h0
`define JTP_OP_SAMPLE   4'h1
`define JTP_OP_IDENT    4'h2
`define JTP_OP_HIGHZ    4'h4
`define JTP_OP_BYPASS   4'hF
`define JTP_ID_W        32
`define JTP_RESET_TMS   5
`endif

/* File: design/jtp_pkg.sv */
// types of the test access port block
package jtp_pkg;
  typedef enum logic [15:0] {
    ST_RESET = 16'h0001, ST_IDLE  = 16'h0002, ST_SELDR = 16'h0004,
    ST_CAPDR = 16'h0008, ST_SHDR  = 16'h0010, ST_EX1DR = 16'h0020,
    ST_PSDR  = 16'h0040, ST_EX2DR = 16'h0080, ST_UPDR  = 16'h0100,
    ST_SELIR = 16'h0200, ST_CAPIR = 16'h0400, ST_SHIR  = 16'h0800,
    ST_EX1IR = 16'h1000, ST_PSIR  = 16'h2000, ST_EX2IR = 16'h4000,
    ST_UPIR  = 16'h8000
  } jtp_state_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } jtp_pins_t;

  typedef struct packed {
    logic [3:0]  version;
    logic [15:0] part;
    logic [10:0] maker;
    logic        one;
  } jtp_id_t;
endpackage : jtp_pkg

/* File: design/jtp_tap.sv */
// test access port controller with instruction and data registers
`include "jtp_params.svh"
module jtp_tap #(
  parameter logic [3:0]  VERSION = 4'h0,    // arbitrary value
  parameter logic [15:0] PART    = 16'h0123, // arbitrary value
  parameter logic [10:0] MAKER   = 11'h155, // arbitrary value
  parameter int          BSR_W   = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire jtp_pkg::jtp_pins_t pins_i,
  input  wire logic [BSR_W-1:0] bsr_capture_i,
  output logic                  tdo_o,
  output logic                  tdo_oe_o,
  output logic                  test_logic_reset_o,
  output logic                  tap_was_reset_o,
  output logic                  extest_o,
  output logic                  outputs_hiz_o,
  output logic                  run_idle_active_o,
  output logic [BSR_W-1:0]      bsr_update_o,
  output logic [3:0]            ir_o
);
  // three-stage synchronisers for every pin input
  logic [2:0] tck_s_r, tms_s_r, tdi_s_r, trst_s_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tck_s_r  <= 3'h0;
      tms_s_r  <= 3'h7;
      tdi_s_r  <= 3'h0;
      trst_s_r <= 3'h0;
    end
    else
    begin
      tck_s_r  <= {tck_s_r[1:0], pins_i.tck};
      tms_s_r  <= {tms_s_r[1:0], pins_i.tms};
      tdi_s_r  <= {tdi_s_r[1:0], pins_i.tdi};
      trst_s_r <= {trst_s_r[1:0], pins_i.trst_n};
    end
  end

  // filtered levels: change once stages two and three agree
  logic tck_f_r, tms_f_r, tdi_f_r, trst_n_f_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tck_f_r    <= 1'b0;
      tms_f_r    <= 1'b1;
      tdi_f_r    <= 1'b0;
      trst_n_f_r <= 1'b0;
    end
    else
    begin
      if (tck_s_r[1] == tck_s_r[2])
        tck_f_r <= tck_s_r[2];
      if (tms_s_r[1] == tms_s_r[2])
        tms_f_r <= tms_s_r[2];
      if (tdi_s_r[1] == tdi_s_r[2])
        tdi_f_r <= tdi_s_r[2];
      if (trst_s_r[1] == trst_s_r[2])
        trst_n_f_r <= trst_s_r[2];
    end
  end

  logic tck_rise, tck_fall;
  assign tck_rise = (tck_s_r[1] == tck_s_r[2]) && tck_s_r[2] && !tck_f_r;
  assign tck_fall = (tck_s_r[1] == tck_s_r[2]) && !tck_s_r[2] && tck_f_r;

  jtp_pkg::jtp_state_t st_r, st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      jtp_pkg::ST_RESET: st_nxt = tms_f_r ? jtp_pkg::ST_RESET
                                          : jtp_pkg::ST_IDLE;
      jtp_pkg::ST_IDLE:  st_nxt = tms_f_r ? jtp_pkg::ST_SELDR
                                          : jtp_pkg::ST_IDLE;
      jtp_pkg::ST_SELDR: st_nxt = tms_f_r ? jtp_pkg::ST_SELIR
                                          : jtp_pkg::ST_CAPDR;
      jtp_pkg::ST_CAPDR: st_nxt = tms_f_r ? jtp_pkg::ST_EX1DR
                                          : jtp_pkg::ST_SHDR;
      jtp_pkg::ST_SHDR:  st_nxt = tms_f_r ? jtp_pkg::ST_EX1DR
                                          : jtp_pkg::ST_SHDR;
      jtp_pkg::ST_EX1DR: st_nxt = tms_f_r ? jtp_pkg::ST_UPDR
                                          : jtp_pkg::ST_PSDR;
      jtp_pkg::ST_PSDR:  st_nxt = tms_f_r ? jtp_pkg::ST_EX2DR
                                          : jtp_pkg::ST_PSDR;
      jtp_pkg::ST_EX2DR: st_nxt = tms_f_r ? jtp_pkg::ST_UPDR
                                          : jtp_pkg::ST_SHDR;
      jtp_pkg::ST_UPDR:  st_nxt = tms_f_r ? jtp_pkg::ST_SELDR
                                          : jtp_pkg::ST_IDLE;
      jtp_pkg::ST_SELIR: st_nxt = tms_f_r ? jtp_pkg::ST_RESET
                                          : jtp_pkg::ST_CAPIR;
      jtp_pkg::ST_CAPIR: st_nxt = tms_f_r ? jtp_pkg::ST_EX1IR
                                          : jtp_pkg::ST_SHIR;
      jtp_pkg::ST_SHIR:  st_nxt = tms_f_r ? jtp_pkg::ST_EX1IR
                                          : jtp_pkg::ST_SHIR;
      jtp_pkg::ST_EX1IR: st_nxt = tms_f_r ? jtp_pkg::ST_UPIR
                                          : jtp_pkg::ST_PSIR;
      jtp_pkg::ST_PSIR:  st_nxt = tms_f_r ? jtp_pkg::ST_EX2IR
                                          : jtp_pkg::ST_PSIR;
      jtp_pkg::ST_EX2IR: st_nxt = tms_f_r ? jtp_pkg::ST_UPIR
                                          : jtp_pkg::ST_SHIR;
      jtp_pkg::ST_UPIR:  st_nxt = tms_f_r ? jtp_pkg::ST_SELDR
                                          : jtp_pkg::ST_IDLE;
      default:           st_nxt = jtp_pkg::ST_RESET;
    endcase
  end

  // trst acts without tck; reset as seen through the synchroniser
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !trst_n_f_r)
      st_r <= jtp_pkg::ST_RESET;
    else if (tck_rise)
      st_r <= st_nxt;
  end

  // rst_i also puts the port in reset, so this flag sets just after it; queue side waits for this flag
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tap_was_reset_o <= 1'b0;
    else if (st_r == jtp_pkg::ST_RESET)
      tap_was_reset_o <= 1'b1;
  end

  // instruction shift stages and latch
  logic [`JTP_IR_W-1:0] ir_sh_r, ir_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ir_sh_r <= `JTP_IR_CAPTURE;
    else if (tck_rise && st_r == jtp_pkg::ST_CAPIR)
      ir_sh_r <= `JTP_IR_CAPTURE;
    else if (tck_rise && st_r == jtp_pkg::ST_SHIR)
      ir_sh_r <= {tdi_f_r, ir_sh_r[`JTP_IR_W-1:1]};
  end

  // reset loads the identification opcode so it is ready at once
  always_ff @(posedge clk_i)
  begin
    if (rst_i || st_r == jtp_pkg::ST_RESET)
      ir_r <= `JTP_OP_IDENT;
    else if (tck_fall && st_r == jtp_pkg::ST_UPIR)
      ir_r <= ir_sh_r;
  end
  assign ir_o = ir_r;

  logic sel_bsr, sel_id;
  assign sel_bsr = (ir_r == `JTP_OP_EXTEST) || (ir_r == `JTP_OP_SAMPLE);
  assign sel_id  = (ir_r == `JTP_OP_IDENT);

  jtp_pkg::jtp_id_t id_val;
  assign id_val = '{version: VERSION, part: PART, maker: MAKER,
                    one: 1'b1};

  logic                  byp_r;
  logic [`JTP_ID_W-1:0]  id_sh_r;
  logic [BSR_W-1:0]      bsr_sh_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      byp_r    <= 1'b0;
      id_sh_r  <= '0;
      bsr_sh_r <= '0;
    end
    else if (tck_rise && st_r == jtp_pkg::ST_CAPDR)
    begin
      if (sel_id)
        id_sh_r <= id_val;
      else if (sel_bsr)
        bsr_sh_r <= bsr_capture_i;
      else
        byp_r <= 1'b0;
    end
    else if (tck_rise && st_r == jtp_pkg::ST_SHDR)
    begin
      if (sel_id)
        id_sh_r <= {tdi_f_r, id_sh_r[`JTP_ID_W-1:1]};
      else if (sel_bsr)
        bsr_sh_r <= {tdi_f_r, bsr_sh_r[BSR_W-1:1]};
      else
        byp_r <= tdi_f_r;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bsr_update_o <= '0;
    else if (tck_fall && st_r == jtp_pkg::ST_UPDR && sel_bsr)
      bsr_update_o <= bsr_sh_r;
  end

  // test modes only after leaving reset; bypass leaves device alone
  assign extest_o           = (st_r != jtp_pkg::ST_RESET) &&
                              (ir_r == `JTP_OP_EXTEST);
  assign outputs_hiz_o      = (st_r != jtp_pkg::ST_RESET) &&
                              (ir_r == `JTP_OP_HIGHZ);
  assign test_logic_reset_o = (st_r == jtp_pkg::ST_RESET);
  // no instruction here runs in idle, so nothing is active there
  assign run_idle_active_o  = 1'b0;

  logic tdo_src;
  always_comb
  begin
    if (st_r == jtp_pkg::ST_SHIR)
      tdo_src = ir_sh_r[0];
    else if (sel_id)
      tdo_src = id_sh_r[0];
    else if (sel_bsr)
      tdo_src = bsr_sh_r[0];
    else
      tdo_src = byp_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_o    <= tdo_src;
      tdo_oe_o <= (st_r == jtp_pkg::ST_SHIR) ||
                  (st_r == jtp_pkg::ST_SHDR);
    end
  end

  // helper: cycles of TMS high counted on tck rises
  logic [2:0] tms_hi_cnt_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tms_hi_cnt_r <= 3'h0;
    else if (tck_rise)
      tms_hi_cnt_r <= !tms_f_r ? 3'h0 :
                      (tms_hi_cnt_r == 3'h7 ? 3'h7 : tms_hi_cnt_r + 3'h1);
  end

  // step checks need trst high; a trst cut is left to a_trst_reset
  a_tms_reset: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tms_hi_cnt_r >= 3'(`JTP_RESET_TMS) |-> st_r == jtp_pkg::ST_RESET)
    else $error("five tms high did not reset");
  a_trst_reset: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !trst_n_f_r |=> st_r == jtp_pkg::ST_RESET)
    else $error("trst did not reset");
  a_state_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !tck_rise && trst_n_f_r |=> $stable(st_r))
    else $error("state moved without tck rise");
  a_seldr_step: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tck_rise && trst_n_f_r && st_r == jtp_pkg::ST_SELDR |=>
      st_r == ($past(tms_f_r) ? jtp_pkg::ST_SELIR : jtp_pkg::ST_CAPDR))
    else $error("select dr step wrong");
  a_selir_step: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tck_rise && trst_n_f_r && st_r == jtp_pkg::ST_SELIR |=>
      st_r == ($past(tms_f_r) ? jtp_pkg::ST_RESET : jtp_pkg::ST_CAPIR))
    else $error("select ir step wrong");
  a_ir_capture: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tck_rise && st_r == jtp_pkg::ST_CAPIR |=>
      ir_sh_r[1:0] == 2'h1)
    else $error("ir capture pattern wrong");
  a_ir_shift: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tck_rise && st_r == jtp_pkg::ST_SHIR |=>
      ir_sh_r[3] == $past(tdi_f_r) && ir_sh_r[2:0] == $past(ir_sh_r[3:1]))
    else $error("ir shift wrong");
  a_pause_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tck_rise && st_r == jtp_pkg::ST_PSIR |=> $stable(ir_sh_r))
    else $error("ir moved in pause");
  a_exit1_ir: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tck_rise && trst_n_f_r && st_r == jtp_pkg::ST_EX1IR |=>
      st_r == ($past(tms_f_r) ? jtp_pkg::ST_UPIR : jtp_pkg::ST_PSIR))
    else $error("exit1 ir step wrong");
  a_ir_update: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tck_fall && st_r == jtp_pkg::ST_UPIR && trst_n_f_r |=>
      ir_r == $past(ir_sh_r))
    else $error("ir update lost");
  a_bypass_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tck_rise && st_r == jtp_pkg::ST_CAPDR && !sel_id && !sel_bsr
      |=> !byp_r)
    else $error("bypass not zero");
  a_id_capture: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tck_rise && st_r == jtp_pkg::ST_CAPDR && sel_id |=>
      id_sh_r[0] == 1'b1 && id_sh_r[31:28] == VERSION)
    else $error("id capture wrong");
  a_bsr_capture: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tck_rise && st_r == jtp_pkg::ST_CAPDR && sel_bsr |=>
      bsr_sh_r == $past(bsr_capture_i))
    else $error("boundary capture wrong");
  a_dr_mirror: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tck_rise && trst_n_f_r && st_r == jtp_pkg::ST_EX1DR |=>
      st_r == ($past(tms_f_r) ? jtp_pkg::ST_UPDR : jtp_pkg::ST_PSDR))
    else $error("exit1 dr step wrong");
  a_bsr_update: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tck_fall && st_r == jtp_pkg::ST_UPDR && sel_bsr |=>
      bsr_update_o == $past(bsr_sh_r))
    else $error("boundary update lost");
  a_bypass_quiet: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ir_r == `JTP_OP_BYPASS |-> !extest_o && !outputs_hiz_o)
    else $error("bypass disturbed device");
  a_was_reset: assert property (
    @(posedge clk_i) disable iff (rst_i)
    st_r == jtp_pkg::ST_RESET |=> tap_was_reset_o)
    else $error("queue release flag missing");
  a_ir_reset: assert property (
    @(posedge clk_i) disable iff (rst_i)
    st_r == jtp_pkg::ST_RESET |=> ir_r == `JTP_OP_IDENT)
    else $error("instruction not reset");
  a_tdo_enable: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tdo_oe_o |-> $past(st_r == jtp_pkg::ST_SHIR ||
      st_r == jtp_pkg::ST_SHDR || tdo_oe_o))
    else $error("tdo driven outside shift");
  a_tdo_steady: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !tck_fall |=> $stable(tdo_o) && $stable(tdo_oe_o))
    else $error("tdo moved without tck fall");
  a_tdo_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tck_fall && st_r != jtp_pkg::ST_SHIR && st_r != jtp_pkg::ST_SHDR
      |=> !tdo_oe_o)
    else $error("tdo left driven");
  a_reset_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    st_r == jtp_pkg::ST_RESET |=> !extest_o && !outputs_hiz_o)
    else $error("test logic active in reset");
endmodule : jtp_tap

/* File: dv/jtp_tester.sv */
// tester model that drives the boundary-scan pins
module jtp_tester (
  input  wire logic          clk_i,
  input  wire logic          tdo_i,
  input  wire logic          tdo_oe_i,
  output jtp_pkg::jtp_pins_t pins_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial pins_o = 4'h5;

  // one test clock of 8 system clocks; returns what the port showed
  // before this rise, as a real tester samples it
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    pins_o.tms <= tms;
    pins_o.tdi <= tdi;
    repeat (4) @(posedge clk_i);
    pins_o.tck <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    // undriven output must not pass for data
    tdo = tdo_oe_i ? tdo_i : 1'bx;
    @(posedge clk_i);
    pins_o.tck <= 1'b0;
  endtask : tick

  task automatic tms_reset();
    logic d;
    repeat (5) tick(1'b1, 1'b0, d);
  endtask : tms_reset

  // pulse long enough to pass the pin synchroniser
  task automatic trst_pulse();
    pins_o.trst_n <= 1'b0;
    repeat (16) @(posedge clk_i);
    pins_o.trst_n <= 1'b1;
    repeat (16) @(posedge clk_i);
  endtask : trst_pulse
endmodule : jtp_tester

/* File: dv/test_jtp_tap.sv */
// self-checking bench for the test access port block
module test_jtp_tap;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0]  VER   = 4'h3;     // arbitrary value
  localparam logic [15:0] PART  = 16'h5A5A; // arbitrary value
  localparam logic [10:0] MAKER = 11'h2AB;  // arbitrary value
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [7:0]         bsr_cap = 8'h00;
  jtp_pkg::jtp_pins_t pins;
  logic               tdo, tdo_oe, tlr, was_reset, extest, hiz, idle_act;
  logic [7:0]         bsr_upd;
  logic [3:0]         ir;
  logic [31:0]        d;
  int                 n_mismatch = 0;
  int                 cmp_count = 0;
  int                 cyc = 0;

  always #2 clk = ~clk;

  jtp_tap #(.VERSION(VER), .PART(PART), .MAKER(MAKER), .BSR_W(8)) dut_u (
    .clk_i(clk), .rst_i(rst), .pins_i(pins), .bsr_capture_i(bsr_cap),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .test_logic_reset_o(tlr),
    .tap_was_reset_o(was_reset), .extest_o(extest), .outputs_hiz_o(hiz),
    .run_idle_active_o(idle_act), .bsr_update_o(bsr_upd), .ir_o(ir));

  jtp_tester tester_u (.clk_i(clk), .tdo_i(tdo), .tdo_oe_i(tdo_oe),
    .pins_o(pins));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask : check

  // from Run-Test-Idle through one scan back to Run-Test-Idle
  task automatic scan(input logic ir_path, input int n,
                      input logic [31:0] din, output logic [31:0] dout);
    logic b;
    dout = '0;
    tester_u.tick(1'b1, 1'b0, b);
    if (ir_path)
      tester_u.tick(1'b1, 1'b0, b);
    tester_u.tick(1'b0, 1'b0, b);
    tester_u.tick(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++)
    begin
      tester_u.tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tester_u.tick(1'b1, 1'b0, b);
    tester_u.tick(1'b0, 1'b0, b);
  endtask : scan

  task automatic load_ir(input logic [3:0] op);
    scan(1'b1, 4, {28'h0, op}, d);
    check(d[3:0], 4'h1);
    check(ir, op);
  endtask : load_ir

  task automatic t_reset();
    check(tlr, 1'b1);
    check(ir, 4'h2);
    check(tdo_oe, 1'b0);
    check(was_reset, 1'b1);
    tester_u.tick(1'b0, 1'b0, d[0]);
    repeat (4) @(posedge clk);
    check(tlr, 1'b0);
    check(idle_act, 1'b0);
  endtask : t_reset

  task automatic t_ident();
    scan(1'b0, 32, 32'h0, d);
    check(d, {VER, PART, MAKER, 1'b1});
  endtask : t_ident

  // bypass must capture zero, then delay tdi by one stage
  task automatic t_bypass();
    load_ir(4'hF);
    scan(1'b0, 4, 32'hB, d);
    check(d[3:0], 4'h6);
    check({extest, hiz}, 2'h0);
  endtask : t_bypass

  task automatic t_opcodes();
    logic [3:0] ops [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'hF};
    foreach (ops[i])
    begin
      load_ir(ops[i]);
      check(extest, ops[i] == 4'h0);
      check(hiz, ops[i] == 4'h4);
    end
  endtask : t_opcodes

  task automatic t_bsr();
    @(posedge clk);
    bsr_cap <= 8'hC5;
    load_ir(4'h0);
    scan(1'b0, 8, 32'h3A, d);
    check(d[7:0], 8'hC5);
    check(bsr_upd, 8'h3A);
    load_ir(4'h3);
    scan(1'b0, 2, 32'h1, d);
    check(d[1:0], 2'h2);
  endtask : t_bsr

  // shift two bits, pause twice, resume through exit2
  task automatic t_pause();
    logic [13:0] tms = 14'b11000100100110;
    logic [13:0] tdi = 14'b00000000001000;
    for (int i = 13; i >= 0; i--)
      tester_u.tick(tms[i], tdi[i], d[0]);
    check(ir, 4'h4);
    check(hiz, 1'b1);
  endtask : t_pause

  task automatic t_tms_reset();
    tester_u.tick(1'b1, 1'b0, d[0]);
    tester_u.tick(1'b0, 1'b0, d[0]);
    tester_u.tick(1'b0, 1'b0, d[0]);
    tester_u.tms_reset();
    repeat (8) @(posedge clk);
    check(tlr, 1'b1);
    check({hiz, ir}, 5'h02);
    tester_u.tick(1'b0, 1'b0, d[0]);
  endtask : t_tms_reset

  task automatic t_trst();
    load_ir(4'h0);
    tester_u.trst_pulse();
    check(tlr, 1'b1);
    check({extest, ir}, 5'h02);
  endtask : t_trst

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // the whole run needs roughly 1500 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    tester_u.trst_pulse();
    t_reset();
    t_ident();
    t_bypass();
    t_opcodes();
    t_bsr();
    t_pause();
    t_tms_reset();
    t_trst();
    finish_test();
  end
endmodule : test_jtp_tap
